// ### rtl/dps_pkg.sv
// Package for the drive power state machine: register map, field layout,
// state encoding and controlword bit positions.
// Assumes a 32-bit APB register bus and a 16-bit cyclic controlword.
`default_nettype none
package dps_pkg;
  // Register byte offsets
  localparam logic [7:0] DPS_OFF_CTRL     = 8'h00;
  localparam logic [7:0] DPS_OFF_STATUS   = 8'h04;
  localparam logic [7:0] DPS_OFF_IRQ_STAT = 8'h08;
  localparam logic [7:0] DPS_OFF_IRQ_MASK = 8'h0c;
  localparam logic [7:0] DPS_OFF_ACYC_CW  = 8'h10;

  // Control register fields
  localparam int DPS_CTRL_NET_MODE  = 0;
  localparam int DPS_CTRL_IF_LSB    = 1;
  localparam int DPS_CTRL_IF_W      = 3;
  localparam int DPS_CTRL_SRC_LSB   = 4;
  localparam int DPS_CTRL_SRC_W     = 4;
  localparam int DPS_CTRL_POS_CTRL  = 8;
  localparam int DPS_CTRL_VEL_MODE  = 9;
  localparam int DPS_CTRL_W         = 10;
  localparam logic [DPS_CTRL_W-1:0] DPS_CTRL_RST = 10'h000;
  // Command interface code meaning the Ethernet connector, source code for network
  localparam logic [DPS_CTRL_IF_W-1:0]  DPS_IF_ETHERNET = 3'h1;
  localparam logic [DPS_CTRL_SRC_W-1:0] DPS_SRC_NETWORK = 4'h0;

  // Status register fields
  localparam int DPS_STAT_STATE_LSB = 0;
  localparam int DPS_STAT_OUT_ACT   = 8;
  localparam int DPS_STAT_CTRL_EN   = 9;
  localparam int DPS_STAT_START     = 10;
  localparam int DPS_STAT_REVERSE   = 11;

  // Interrupt events
  localparam int DPS_IRQ_W          = 3;
  localparam int DPS_IRQ_STATE_CHG  = 0;
  localparam int DPS_IRQ_FAULT      = 1;
  localparam int DPS_IRQ_BLOCKED    = 2;
  localparam logic [DPS_IRQ_W-1:0] DPS_IRQ_RST = 3'h0;

  localparam int DPS_CW_W  = 16;
  localparam int DPS_VEL_W = 32;
  localparam logic [DPS_CW_W-1:0] DPS_CW_RST = 16'h0000;

  // Drive states, one-hot
  typedef enum logic [7:0] {
    DPS_NOT_READY    = 8'h01,
    DPS_SW_ON_DIS    = 8'h02,
    DPS_READY        = 8'h04,
    DPS_SWITCHED_ON  = 8'h08,
    DPS_OP_ENABLED   = 8'h10,
    DPS_QUICK_STOP   = 8'h20,
    DPS_FAULT_REACT  = 8'h40,
    DPS_FAULT        = 8'h80
  } dps_state_t;

  // Controlword bit positions
  localparam int DPS_CW_SWITCH_ON = 0;
  localparam int DPS_CW_EN_VOLT   = 1;
  localparam int DPS_CW_QUICK     = 2;
  localparam int DPS_CW_EN_OP     = 3;
  localparam int DPS_CW_FLT_RST   = 7;
endpackage : dps_pkg
`default_nettype wire

// ### rtl/dps_sync.sv
// Two flip-flop synchroniser for a group of independent level inputs.
// Assumes each bit is a slow level; no bits are sampled coherently together.
`default_nettype none
module dps_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  genvar i;
  // One chain per bit; the first stage feeds only the second
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic meta_q;
      logic sync_q;
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          meta_q <= 1'b0;
          sync_q <= 1'b0;
        end else begin
          meta_q <= d[i];
          sync_q <= meta_q;
        end
      end
      assign q[i] = sync_q;
    end
  endgenerate
endmodule : dps_sync
`default_nettype wire

// ### rtl/dps_top.sv
// Drive power state machine: steps the drive through its eight states from
// cyclic controlword commands and fixes the output behaviour of each state.
// Assumes cyclic data, bus state and velocity targets come from logic on pclk;
// fault and output-stop arrive from pins and are synchronised here.
//
// The address map and register access over APB were chosen for this implementation.
`default_nettype none
module dps_top
  import dps_pkg::*;
(
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  // APB slave
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [7:0]                  paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  output logic                             irq,
  // Cyclic process data and bus state
  input  wire logic                        bus_operational,
  input  wire logic                        cyclic_cw_valid,
  input  wire logic [dps_pkg::DPS_CW_W-1:0] cyclic_cw,
  input  wire logic [dps_pkg::DPS_VEL_W-1:0] vel_mode_target,
  input  wire logic [dps_pkg::DPS_VEL_W-1:0] target_velocity,
  // Drive side
  input  wire logic                        init_done,
  input  wire logic                        drive_stopped,
  input  wire logic                        fault_pin,
  input  wire logic                        output_stop_input,
  input  wire logic                        local_servo_on,
  input  wire logic                        local_start,
  output logic [7:0]                       state_feedback,
  output logic                             output_active_indicator,
  output logic                             servo_on_input,
  output logic                             start_cmd,
  output logic                             start_reverse,
  output logic                             sudden_stop_input,
  output logic                             emergency_stop_input,
  output logic                             cap_life_meas_en,
  output logic                             control_enabled
);
  // Registers
  dps_state_t              state_q;
  dps_state_t              state_d;
  logic [DPS_CTRL_W-1:0]   ctrl_q;
  logic [DPS_IRQ_W-1:0]    irq_stat_q;
  logic [DPS_IRQ_W-1:0]    irq_mask_q;
  logic [DPS_CW_W-1:0]     acyc_cw_q;
  logic                    flt_rst_prev_q;
  logic                    run_q;
  logic [31:0]             prdata_q;
  logic                    pready_q;
  logic                    pslverr_q;
  logic                    irq_q;
  logic                    out_act_q;
  logic                    servo_q;
  logic                    start_q;
  logic                    reverse_q;
  logic                    sudden_q;
  logic                    emerg_q;
  logic                    cap_en_q;
  logic                    ctrl_en_q;

  // Synchronised pins
  logic [1:0]              pins_s;
  logic                    fault_s;
  logic                    out_stop_s;

  // Decode
  logic                    ctrl_en;
  logic                    take;
  logic                    c_shutdown;
  logic                    c_switch_on;
  logic                    c_enable_op;
  logic                    c_disable_op;
  logic                    c_dis_volt;
  logic                    c_quick;
  logic                    c_flt_rst;
  logic                    apb_access;
  logic                    apb_wr;
  logic                    addr_ok;
  logic [DPS_IRQ_W-1:0]    ev;
  logic [DPS_IRQ_W-1:0]    irq_clr;
  logic                    on_state;

  dps_sync #(.WIDTH (2)) u_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .d     ({output_stop_input, fault_pin}),
    .q     (pins_s)
  );
  assign fault_s    = pins_s[0];
  assign out_stop_s = pins_s[1];

  // Bus control gate: all three settings plus the running cyclic exchange
  assign ctrl_en = ctrl_q[DPS_CTRL_NET_MODE] &
                   (ctrl_q[DPS_CTRL_IF_LSB +: DPS_CTRL_IF_W] == DPS_IF_ETHERNET) &
                   (ctrl_q[DPS_CTRL_SRC_LSB +: DPS_CTRL_SRC_W] == DPS_SRC_NETWORK) &
                   bus_operational;
  // Only the cyclic path feeds the command decoder
  assign take = ctrl_en & cyclic_cw_valid;

  // Controlword command decode; fault reset bit low for all but fault reset
  always_comb begin
    c_dis_volt   = ~cyclic_cw[DPS_CW_EN_VOLT] & ~cyclic_cw[DPS_CW_FLT_RST];
    c_quick      = cyclic_cw[DPS_CW_EN_VOLT] & ~cyclic_cw[DPS_CW_QUICK] & ~cyclic_cw[DPS_CW_FLT_RST];
    c_shutdown   = cyclic_cw[DPS_CW_QUICK] & cyclic_cw[DPS_CW_EN_VOLT] & ~cyclic_cw[DPS_CW_SWITCH_ON] &
                   ~cyclic_cw[DPS_CW_FLT_RST];
    c_switch_on  = cyclic_cw[DPS_CW_QUICK] & cyclic_cw[DPS_CW_EN_VOLT] & cyclic_cw[DPS_CW_SWITCH_ON] &
                   ~cyclic_cw[DPS_CW_EN_OP] & ~cyclic_cw[DPS_CW_FLT_RST];
    c_disable_op = c_switch_on;
    c_enable_op  = cyclic_cw[DPS_CW_QUICK] & cyclic_cw[DPS_CW_EN_VOLT] & cyclic_cw[DPS_CW_SWITCH_ON] &
                   cyclic_cw[DPS_CW_EN_OP] & ~cyclic_cw[DPS_CW_FLT_RST];
    c_flt_rst    = cyclic_cw[DPS_CW_FLT_RST] & ~flt_rst_prev_q;
  end

  // Fault reset acts on the rising edge of its bit only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flt_rst_prev_q <= 1'b0;
    end else if (take) begin
      flt_rst_prev_q <= cyclic_cw[DPS_CW_FLT_RST];
    end
  end

  // Next state; a fault overrides every command and needs no bus control
  always_comb begin
    state_d = state_q;
    case (state_q)
      DPS_NOT_READY: begin
        if (init_done) state_d = DPS_SW_ON_DIS;
      end
      DPS_SW_ON_DIS: begin
        if (take && c_shutdown) state_d = DPS_READY;
      end
      DPS_READY: begin
        if (take && c_switch_on) state_d = DPS_SWITCHED_ON;
        else if (take && (c_dis_volt || c_quick)) state_d = DPS_SW_ON_DIS;
      end
      DPS_SWITCHED_ON: begin
        if (take && c_enable_op && out_act_q) state_d = DPS_OP_ENABLED;
        else if (take && c_shutdown) state_d = DPS_READY;
        else if (take && (c_dis_volt || c_quick)) state_d = DPS_SW_ON_DIS;
      end
      DPS_OP_ENABLED: begin
        // Leaving to Switched on waits for the drive to stop, or for the indicator to drop
        if (take && c_disable_op && drive_stopped) state_d = DPS_SWITCHED_ON;
        else if (!out_act_q) state_d = DPS_SWITCHED_ON;
        else if (take && c_shutdown) state_d = DPS_READY;
        else if (take && c_dis_volt) state_d = DPS_SW_ON_DIS;
        else if (take && c_quick) state_d = DPS_QUICK_STOP;
      end
      DPS_QUICK_STOP: begin
        if ((take && c_dis_volt) || drive_stopped) state_d = DPS_SW_ON_DIS;
      end
      DPS_FAULT_REACT: begin
        state_d = DPS_FAULT;
      end
      DPS_FAULT: begin
        if (take && c_flt_rst && !fault_s) state_d = DPS_SW_ON_DIS;
      end
      default: begin
        state_d = DPS_NOT_READY;
      end
    endcase
    if (fault_s && state_q != DPS_FAULT_REACT && state_q != DPS_FAULT) begin
      state_d = DPS_FAULT_REACT;
    end
  end

  // State register; one-hot value always one of eight
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= DPS_NOT_READY;
    end else begin
      state_q <= state_d;
    end
  end

  // Run latch: set by enable operation, cleared by disable operation or leaving
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q <= 1'b0;
    end else if (state_q != DPS_OP_ENABLED) begin
      run_q <= (state_d == DPS_OP_ENABLED);
    end else if (take && c_enable_op) begin
      run_q <= 1'b1;
    end else if (take && c_disable_op) begin
      run_q <= 1'b0;
    end
  end

  // States in which output shutoff is cancelled
  assign on_state = (state_q == DPS_SWITCHED_ON) || (state_q == DPS_OP_ENABLED) ||
                    (state_q == DPS_QUICK_STOP);

  // Output-active indicator; registered so it lags the state by one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_act_q <= 1'b0;
    end else begin
      out_act_q <= on_state && !out_stop_s && !fault_s;
    end
  end

  // Servo-on and start; local sources only while bus control is off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      servo_q <= 1'b0;
      start_q <= 1'b0;
    end else if (ctrl_en) begin
      servo_q <= ctrl_q[DPS_CTRL_POS_CTRL] && (state_q == DPS_OP_ENABLED);
      start_q <= !ctrl_q[DPS_CTRL_POS_CTRL] && (state_q == DPS_OP_ENABLED) && run_q;
    end else begin
      servo_q <= local_servo_on;
      start_q <= local_start;
    end
  end

  // Stop functions follow the control mode while in Quick stop active
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sudden_q <= 1'b0;
      emerg_q  <= 1'b0;
    end else begin
      sudden_q <= (state_q == DPS_QUICK_STOP) && ctrl_q[DPS_CTRL_POS_CTRL];
      emerg_q  <= (state_q == DPS_QUICK_STOP) && !ctrl_q[DPS_CTRL_POS_CTRL];
    end
  end

  // Direction is the sign bit of the selected velocity target
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reverse_q <= 1'b0;
    end else begin
      reverse_q <= ctrl_q[DPS_CTRL_VEL_MODE] ? vel_mode_target[DPS_VEL_W-1] :
                                               target_velocity[DPS_VEL_W-1];
    end
  end

  // Enable flags; capacitor measurement would disturb bus-driven operation
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_en_q <= 1'b0;
      cap_en_q  <= 1'b1;
    end else begin
      ctrl_en_q <= ctrl_en;
      cap_en_q  <= !ctrl_en;
    end
  end

  // APB: one wait state; writes land only on the completing edge, when pready is seen high
  assign apb_access = psel && penable && !pready_q;
  assign apb_wr     = psel && penable && pwrite && pready_q;
  assign addr_ok    = (paddr == DPS_OFF_CTRL) || (paddr == DPS_OFF_STATUS) || (paddr == DPS_OFF_IRQ_STAT) ||
                      (paddr == DPS_OFF_IRQ_MASK) || (paddr == DPS_OFF_ACYC_CW);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= apb_access;
      pslverr_q <= apb_access && !addr_ok;
    end
  end

  // Read data captured with the answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (apb_access && !pwrite) begin
      prdata_q <= 32'h0000_0000;
      case (paddr)
        DPS_OFF_CTRL: begin
          prdata_q[DPS_CTRL_W-1:0] <= ctrl_q;
        end
        DPS_OFF_STATUS: begin
          prdata_q[DPS_STAT_STATE_LSB +: 8] <= state_q;
          prdata_q[DPS_STAT_OUT_ACT]        <= out_act_q;
          prdata_q[DPS_STAT_CTRL_EN]        <= ctrl_en_q;
          prdata_q[DPS_STAT_START]          <= start_q;
          prdata_q[DPS_STAT_REVERSE]        <= reverse_q;
        end
        DPS_OFF_IRQ_STAT: begin
          prdata_q[DPS_IRQ_W-1:0] <= irq_stat_q;
        end
        DPS_OFF_IRQ_MASK: begin
          prdata_q[DPS_IRQ_W-1:0] <= irq_mask_q;
        end
        DPS_OFF_ACYC_CW: begin
          prdata_q[DPS_CW_W-1:0] <= acyc_cw_q;
        end
        default: begin
          prdata_q <= 32'h0000_0000;
        end
      endcase
    end
  end

  // Writable registers; the acyclic controlword is kept for read-back only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q     <= DPS_CTRL_RST;
      irq_mask_q <= DPS_IRQ_RST;
      acyc_cw_q  <= DPS_CW_RST;
    end else if (apb_wr) begin
      if (paddr == DPS_OFF_CTRL) ctrl_q <= pwdata[DPS_CTRL_W-1:0];
      if (paddr == DPS_OFF_IRQ_MASK) irq_mask_q <= pwdata[DPS_IRQ_W-1:0];
      if (paddr == DPS_OFF_ACYC_CW) acyc_cw_q <= pwdata[DPS_CW_W-1:0];
    end
  end

  // Sticky events; a new event wins over a clear in the same cycle
  assign ev[DPS_IRQ_STATE_CHG] = (state_d != state_q);
  assign ev[DPS_IRQ_FAULT]     = (state_d == DPS_FAULT_REACT) && (state_q != DPS_FAULT_REACT);
  assign ev[DPS_IRQ_BLOCKED]   = (state_q == DPS_SWITCHED_ON) && take && c_enable_op && !out_act_q;
  assign irq_clr = (apb_wr && paddr == DPS_OFF_IRQ_STAT) ? pwdata[DPS_IRQ_W-1:0] : DPS_IRQ_RST;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_q <= DPS_IRQ_RST;
      irq_q      <= 1'b0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~irq_clr) | ev;
      irq_q      <= |(((irq_stat_q & ~irq_clr) | ev) & irq_mask_q);
    end
  end

  // Outputs straight from flops
  assign prdata                  = prdata_q;
  assign pready                  = pready_q;
  assign pslverr                 = pslverr_q;
  assign irq                     = irq_q;
  assign state_feedback          = state_q;
  assign output_active_indicator = out_act_q;
  assign servo_on_input          = servo_q;
  assign start_cmd               = start_q;
  assign start_reverse           = reverse_q;
  assign sudden_stop_input       = sudden_q;
  assign emergency_stop_input    = emerg_q;
  assign cap_life_meas_en        = cap_en_q;
  assign control_enabled         = ctrl_en_q;
endmodule : dps_top
`default_nettype wire

// ### dv/dps_master_model.sv
// Cyclic fieldbus master model: sends one controlword per send request.
// Assumes the bench raises send for one pclk cycle and holds op_req as a level.
`default_nettype none
module dps_master_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        op_req,
  input  wire logic        send,
  input  wire logic [15:0] word,
  output logic             bus_operational,
  output logic             cyclic_cw_valid,
  output logic      [15:0] cyclic_cw
);
  timeunit 1ns;
  timeprecision 1ps;
  // Words only go out while cyclic exchange runs; idle data toggles so no stale word looks valid
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_operational <= 1'b0;
      cyclic_cw_valid <= 1'b0;
      cyclic_cw       <= 16'h0000;
    end else begin
      bus_operational <= op_req;
      cyclic_cw_valid <= send && op_req;
      cyclic_cw       <= (send && op_req) ? word : ~cyclic_cw;
    end
  end
endmodule : dps_master_model
`default_nettype wire

// ### dv/dps_monitor.sv
// Checker on the state machine ports of dps_top.
// Assumes one pclk domain and outputs that lag the state by one cycle.
`default_nettype none
module dps_monitor (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic [7:0] state_feedback,
  input wire logic       output_active_indicator,
  input wire logic       output_stop_input,
  input wire logic       init_done,
  input wire logic       fault_pin,
  input wire logic       bus_operational,
  input wire logic       control_enabled,
  input wire logic       cap_life_meas_en,
  input wire logic       emergency_stop_input,
  input wire logic       sudden_stop_input
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // One state at a time
  property p_onehot; $onehot(state_feedback); endproperty
  a_onehot: assert property (p_onehot)
    else $error("state not one-hot");
  // Shutoff states other than fault reaction keep the indicator low
  property p_off; state_feedback inside {8'h01, 8'h02, 8'h04, 8'h80} |=> !output_active_indicator; endproperty
  a_off: assert property (p_off)
    else $error("indicator high in shutoff state");
  // Allow the two sync stages plus the output register
  property p_ostop; output_stop_input [*4] |-> !output_active_indicator; endproperty
  a_ostop: assert property (p_ostop)
    else $error("indicator high under output stop");
  property p_block; state_feedback == 8'h08 && !output_active_indicator |=> state_feedback != 8'h10; endproperty
  a_block: assert property (p_block)
    else $error("enable operation not blocked");
  property p_qstop; state_feedback == 8'h20 |=> emergency_stop_input || sudden_stop_input; endproperty
  a_qstop: assert property (p_qstop)
    else $error("quick stop without stop function");
  property p_cap; control_enabled [*2] |-> !cap_life_meas_en; endproperty
  a_cap: assert property (p_cap)
    else $error("capacitor measurement under control");
  property p_fault; state_feedback == 8'h40 |=> state_feedback == 8'h80; endproperty
  a_fault: assert property (p_fault)
    else $error("fault reaction did not reach fault");
  property p_init; state_feedback == 8'h01 && init_done && !fault_pin |=> state_feedback == 8'h02; endproperty
  a_init: assert property (p_init)
    else $error("no leave after initialisation");
  property p_busop; !bus_operational |=> !control_enabled; endproperty
  a_busop: assert property (p_busop)
    else $error("control enabled without bus");
endmodule : dps_monitor
`default_nettype wire

// ### dv/dps_tb.sv
// Self-checking bench for dps_top: APB tasks, master model, scenario tasks.
// Assumes the one-wait-state APB slave and one-cycle state update of the design.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import dps_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, op_req, send;
  logic [7:0]  paddr, state_feedback;
  logic [31:0] pwdata, prdata, vel_mode_target, target_velocity, r;
  logic [15:0] word, cyclic_cw;
  logic        bus_operational, cyclic_cw_valid, init_done, drive_stopped, fault_pin, e;
  logic        output_stop_input, local_servo_on, local_start, output_active_indicator;
  logic        servo_on_input, start_cmd, start_reverse, sudden_stop_input, emergency_stop_input;
  logic        cap_life_meas_en, control_enabled;
  int          bad_count, n_checks;
  dps_master_model u_master (.pclk(pclk), .presetn(presetn), .op_req(op_req), .send(send), .word(word),
    .bus_operational(bus_operational), .cyclic_cw_valid(cyclic_cw_valid), .cyclic_cw(cyclic_cw));
  dps_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .bus_operational(bus_operational), .cyclic_cw_valid(cyclic_cw_valid), .cyclic_cw(cyclic_cw),
    .vel_mode_target(vel_mode_target), .target_velocity(target_velocity), .init_done(init_done),
    .drive_stopped(drive_stopped), .fault_pin(fault_pin), .output_stop_input(output_stop_input),
    .local_servo_on(local_servo_on), .local_start(local_start), .state_feedback(state_feedback),
    .output_active_indicator(output_active_indicator), .servo_on_input(servo_on_input),
    .start_cmd(start_cmd), .start_reverse(start_reverse), .sudden_stop_input(sudden_stop_input),
    .emergency_stop_input(emergency_stop_input), .cap_life_meas_en(cap_life_meas_en),
    .control_enabled(control_enabled));
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  task automatic summarize;
    if (bad_count == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_checks++;
    if (g !== x) begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, g, x);
    end
  endtask : chk
  task automatic st(input logic [7:0] s, input logic i);
    chk(state_feedback, s);
    chk(output_active_indicator, i);
  endtask : st
  // One APB transfer; the extra edge keeps psel from being assigned twice in one step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      bad_count++;
      $display("[ERR] %0t apb wait timed out", $time);
      summarize();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  // Model sends next edge, design takes it one edge later, outputs follow
  task automatic cw(input logic [15:0] w);
    word <= w;
    send <= 1'b1;
    @(posedge pclk);
    send <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask : cw
  task automatic t_gate;
    chk(control_enabled, 1'b0);
    local_start <= 1'b1;
    op_req <= 1'b1;
    // Source code 1 is not network, so the shutdown below must be ignored
    apb(1'b1, DPS_OFF_CTRL, 32'h013);
    cw(16'h0006);
    st(8'h02, 1'b0);
    apb(1'b1, DPS_OFF_CTRL, 32'h003);
    apb(1'b1, DPS_OFF_ACYC_CW, 32'h6);
    repeat (3) @(posedge pclk);
    st(8'h02, 1'b0);
    chk(control_enabled, 1'b1);
    chk(cap_life_meas_en, 1'b0);
    chk(start_cmd, 1'b0);
    local_start <= 1'b0;
  endtask : t_gate
  task automatic t_walk;
    target_velocity <= 32'hffff_fff0;
    cw(16'h0006);
    st(8'h04, 1'b0);
    cw(16'h0007);
    st(8'h08, 1'b1);
    cw(16'h000f);
    st(8'h10, 1'b1);
    chk(start_cmd, 1'b1);
    chk(start_reverse, 1'b1);
    cw(16'h0007);
    chk(start_cmd, 1'b0);
    st(8'h10, 1'b1);
    cw(16'h0002);
    chk(emergency_stop_input, 1'b1);
    st(8'h20, 1'b1);
    drive_stopped <= 1'b1;
    repeat (3) @(posedge pclk);
    st(8'h02, 1'b0);
    drive_stopped <= 1'b0;
  endtask : t_walk
  task automatic t_stop;
    cw(16'h0006);
    cw(16'h0007);
    output_stop_input <= 1'b1;
    repeat (5) @(posedge pclk);
    st(8'h08, 1'b0);
    apb(1'b1, DPS_OFF_IRQ_STAT, 32'h7);
    cw(16'h000f);
    st(8'h08, 1'b0);
    apb(1'b0, DPS_OFF_IRQ_STAT, 32'h0);
    chk(r[2], 1'b1);
    chk(irq, 1'b0);
    apb(1'b1, DPS_OFF_IRQ_MASK, 32'h4);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b1);
    apb(1'b1, DPS_OFF_IRQ_STAT, 32'h4);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b0);
    apb(1'b0, 8'h40, 32'h0);
    chk(e, 1'b1);
    chk(r, 32'h0000_0000);
    output_stop_input <= 1'b0;
    repeat (5) @(posedge pclk);
    st(8'h08, 1'b1);
  endtask : t_stop
  task automatic t_fault;
    fault_pin <= 1'b1;
    repeat (6) @(posedge pclk);
    st(8'h80, 1'b0);
    apb(1'b0, DPS_OFF_IRQ_STAT, 32'h0);
    chk(r[1], 1'b1);
    fault_pin <= 1'b0;
    repeat (3) @(posedge pclk);
    cw(16'h0000);
    cw(16'h0080);
    st(8'h02, 1'b0);
    // State 02, control enabled, reverse from the negative target velocity
    apb(1'b0, DPS_OFF_STATUS, 32'h0);
    chk(r, 32'h0000_0a02);
  endtask : t_fault
  task automatic t_pos;
    vel_mode_target <= 32'h0000_0010;
    // Position control, velocity-mode target
    apb(1'b1, DPS_OFF_CTRL, 32'h303);
    cw(16'h0006);
    cw(16'h0007);
    cw(16'h000f);
    st(8'h10, 1'b1);
    chk(servo_on_input, 1'b1);
    chk(start_reverse, 1'b0);
    cw(16'h0002);
    chk(sudden_stop_input, 1'b1);
    chk(emergency_stop_input, 1'b0);
  endtask : t_pos
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    op_req = 1'b0;
    send = 1'b0;
    word = 16'h0;
    init_done = 1'b0;
    drive_stopped = 1'b0;
    fault_pin = 1'b0;
    output_stop_input = 1'b0;
    local_servo_on = 1'b0;
    local_start = 1'b0;
    vel_mode_target = 32'h0;
    target_velocity = 32'h0;
    bad_count = 0;
    n_checks = 0;
    repeat (8) @(posedge pclk);
    st(8'h01, 1'b0);
    chk(cap_life_meas_en, 1'b1);
    presetn <= 1'b1;
    init_done <= 1'b1;
    repeat (3) @(posedge pclk);
    st(8'h02, 1'b0);
    t_gate();
    t_walk();
    t_stop();
    t_fault();
    t_pos();
    summarize();
  end
endmodule : testbench
bind dps_top dps_monitor u_mon (.pclk(pclk), .presetn(presetn), .state_feedback(state_feedback),
  .output_active_indicator(output_active_indicator), .output_stop_input(output_stop_input),
  .init_done(init_done), .fault_pin(fault_pin), .bus_operational(bus_operational),
  .control_enabled(control_enabled), .cap_life_meas_en(cap_life_meas_en),
  .emergency_stop_input(emergency_stop_input), .sudden_stop_input(sudden_stop_input));
`default_nettype wire
